// file: adc_seq_consts.svh
// register map, field positions and reset values of the sequence controller
// assumes inclusion by bare name from the controller and its testbench
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH
// word indices; byte address is four times the index
`define IDX_FLAG_CTL    6'h02
`define IDX_SEQ_CTL     6'h03
`define IDX_STATUS0     6'h06
`define IDX_CCF         6'h0B
`define IDX_RES_BASE    3'h2
// sequence control fields
`define SEQ_CTL_RESET   8'h20
`define SEQ_CTL_MASK    8'h7F
`define LEN_HI          6
`define LEN_LO          3
`define FIFO_BIT        2
`define FRZ_HI          1
`define FRZ_LO          0
`define FAST_CLR_BIT    6
`define FRZ_CONTINUE    2'h0
`define FRZ_RESERVED    2'h1
`define FRZ_FINISH      2'h2
`define FRZ_NOW         2'h3
`define LEN_FULL        4'h8
`define CNT_LAST        3'h7
`endif

// file: adc_seq_pkg.sv
// types shared by the sequence controller and its result file
// assumes adc_seq_consts.svh is on the include path
package adc_seq_pkg;
  // one conversion result handed over by the converter core
  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } conv_result_t;

  // freeze handling states, one-hot
  typedef enum logic [2:0] {
    FZ_RUN    = 3'b001,
    FZ_DRAIN  = 3'b010,
    FZ_FROZEN = 3'b100
  } freeze_state_t;
endpackage

// file: result_file.sv
// eight result slots with their conversion complete flags
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module result_file
  import adc_seq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_en_i,
  input  wire logic [2:0] wr_idx_i,
  input  wire logic [9:0] wr_data_i,
  input  wire logic [7:0] clr_mask_i,
  input  wire logic [2:0] rd_idx_i,
  output logic      [9:0] rd_data_o,
  output logic      [7:0] ccf_o
);
  logic [9:0] slot_q [8];

  // ****************************************
  // per-slot storage and flag
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_slot
      // data kept on write, value cleared to zero by reset
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          slot_q[gi] <= 10'h000;
        else if (wr_en_i && wr_idx_i == 3'(gi))
          slot_q[gi] <= wr_data_i;
      end

      // set wins over a clear in the same cycle, so no result is lost
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          ccf_o[gi] <= 1'b0;
        else if (wr_en_i && wr_idx_i == 3'(gi))
          ccf_o[gi] <= 1'b1;
        else if (clr_mask_i[gi])
          ccf_o[gi] <= 1'b0;
      end
    end
  endgenerate

  assign rd_data_o = slot_q[rd_idx_i];
endmodule // result_file

// file: adc_sequence_fifo_freeze_ctrl.sv
// sequence length, result placement and freeze control of an a/d controller
// assumes a classic wishbone master and a converter core on the same clock
//
// Behaviour
// - writing sequence control aborts a running sequence and starts nothing
// - length code 0 or top bit set gives eight, else one to seven
// - reset leaves length code at four conversions
// - without fifo mode, result n of a sequence goes to slot n
// - fifo mode keeps the counter across sequence end and scan restart
// - fifo mode counter wraps from last slot back to slot zero
// - conversion counter readable in status register zero
// - abort, control register write or start_i pulse clears the counter, fifo mode too
// - one complete flag per slot, set when that slot receives a result
// - freeze field: continue, reserved, finish then freeze, freeze now
// - freeze behaviour applies while the debug breakpoint is asserted
// - fast clear: any slot access clears flag; else status read then slot read
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_sequence_fifo_freeze_ctrl
  import adc_seq_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         abort_i,
  input  wire logic         start_i,
  input  wire logic         scan_i,
  input  wire logic         external_trigger_mode_i,
  input  wire logic         freeze_i,
  input  wire logic         conv_busy_i,
  input  wire conv_result_t conv_result_i,
  output logic      [3:0]   seq_len_o,
  output logic              fifo_mode_o,
  output logic              abort_o,
  output logic              seq_done_o,
  output logic              conv_enable_o,
  output logic              halt_o
);
  // ****************************************
  // declarations
  // ****************************************
  logic [7:0]    seq_ctl_q;
  logic          fast_clr_q;
  logic [2:0]    cnt_q;
  logic [3:0]    pos_q;
  logic          active_q;
  logic [7:0]    armed_q;
  logic [7:0]    clr_mask;
  logic [7:0]    ccf;
  logic [9:0]    rd_res;
  logic [5:0]    word;
  logic          req;
  logic          acc;
  logic          wr_acc;
  logic          rd_acc;
  logic          res_hit;
  logic          accept;
  logic          last;
  logic          clear_cnt;
  logic [3:0]    code;
  logic [1:0]    frz;
  freeze_state_t fz_q;

  assign word    = wb_adr_i[7:2];
  assign req     = wb_cyc_i && wb_stb_i;
  assign acc     = req && wb_ack_o;
  assign wr_acc  = acc && wb_we_i && wb_sel_i[0];
  assign rd_acc  = acc && !wb_we_i;
  assign res_hit = word[5:3] == `IDX_RES_BASE;
  assign code    = seq_ctl_q[`LEN_HI:`LEN_LO];
  assign frz     = seq_ctl_q[`FRZ_HI:`FRZ_LO];

  // ****************************************
  // wishbone slave
  // ****************************************
  // ack one cycle after the request; the access acts on the ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req && !wb_ack_o;
  end

  // read data registered with the ack; unmapped words read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_ack_o)
    begin
      wb_dat_o <= 32'h0000_0000;
      if (res_hit)
        wb_dat_o[9:0] <= rd_res;
      else
        unique case (word)
          `IDX_SEQ_CTL:  wb_dat_o[7:0] <= seq_ctl_q;
          `IDX_FLAG_CTL: wb_dat_o[`FAST_CLR_BIT] <= fast_clr_q;
          `IDX_STATUS0:  wb_dat_o[7:0] <= {3'h0, halt_o, active_q, cnt_q};
          `IDX_CCF:      wb_dat_o[7:0] <= ccf;
          default:       wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  // reserved bit seven never stores
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seq_ctl_q <= `SEQ_CTL_RESET;
    else if (wr_acc && word == `IDX_SEQ_CTL)
      seq_ctl_q <= wb_dat_i[7:0] & `SEQ_CTL_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fast_clr_q <= 1'b0;
    else if (wr_acc && word == `IDX_FLAG_CTL)
      fast_clr_q <= wb_dat_i[`FAST_CLR_BIT];
  end

  // length decode: zero and any code with bit three set mean eight
  always_comb
  begin
    if (code == 4'h0 || code[3])
      seq_len_o = `LEN_FULL;
    else
      seq_len_o = {1'b0, code[2:0]};
  end

  assign fifo_mode_o = seq_ctl_q[`FIFO_BIT];

  // ****************************************
  // abort and sequence tracking
  // ****************************************
  // a write to either control register aborts; neither one starts
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      abort_o <= 1'b0;
    else
      abort_o <= wr_acc && (word == `IDX_SEQ_CTL || word == `IDX_FLAG_CTL);
  end

  // results are taken only inside a sequence
  assign accept    = conv_result_i.valid && active_q;
  assign last      = pos_q + 4'h1 == seq_len_o;
  assign clear_cnt = abort_o || abort_i || start_i;

  // scan restarts the sequence; otherwise the sequence ends
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      active_q <= 1'b0;
      pos_q    <= 4'h0;
    end
    else if (abort_o || abort_i)
    begin
      active_q <= 1'b0;
      pos_q    <= 4'h0;
    end
    else if (start_i)
    begin
      active_q <= 1'b1;
      pos_q    <= 4'h0;
    end
    else if (accept)
    begin
      pos_q    <= last ? 4'h0 : pos_q + 4'h1;
      active_q <= !last || scan_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      seq_done_o <= 1'b0;
    else
      seq_done_o <= accept && last && !clear_cnt;
  end

  // counter: fifo mode rolls on through sequence edges, else follows position
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cnt_q <= 3'h0;
    else if (clear_cnt)
      cnt_q <= 3'h0;
    else if (accept && fifo_mode_o)
      cnt_q <= cnt_q + 3'h1;
    else if (accept)
      cnt_q <= last ? 3'h0 : cnt_q + 3'h1;
  end

  // ****************************************
  // flag clearing
  // ****************************************
  // normal mode: a status read arms the flags it saw, a slot read clears
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      armed_q <= 8'h00;
    else if (rd_acc && word == `IDX_CCF)
      armed_q <= ccf;
    else if (rd_acc && res_hit)
      armed_q[word[2:0]] <= 1'b0;
  end

  always_comb
  begin
    clr_mask = 8'h00;
    if (acc && res_hit && fast_clr_q)
      clr_mask[word[2:0]] = 1'b1;
    else if (rd_acc && res_hit && armed_q[word[2:0]])
      clr_mask[word[2:0]] = 1'b1;
  end

  result_file u_results (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_en_i    (accept && !clear_cnt),
    .wr_idx_i   (cnt_q),
    .wr_data_i  (conv_result_i.data),
    .clr_mask_i (clr_mask),
    .rd_idx_i   (word[2:0]),
    .rd_data_o  (rd_res),
    .ccf_o      (ccf)
  );

  // ****************************************
  // breakpoint freeze
  // ****************************************
  // reserved code 01 behaves as continue; immediate freeze may cost accuracy
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      fz_q <= FZ_RUN;
    else
      unique case (fz_q)
        FZ_RUN:
          if (freeze_i && frz == `FRZ_NOW)
            fz_q <= FZ_FROZEN;
          else if (freeze_i && frz == `FRZ_FINISH)
            fz_q <= conv_busy_i ? FZ_DRAIN : FZ_FROZEN;
        FZ_DRAIN:
          if (!freeze_i)
            fz_q <= FZ_RUN;
          else if (!conv_busy_i)
            fz_q <= FZ_FROZEN;
        FZ_FROZEN:
          if (!freeze_i)
            fz_q <= FZ_RUN;
        default:
          fz_q <= FZ_RUN;
      endcase
  end

  assign halt_o        = fz_q == FZ_FROZEN;
  // draining lets the running conversion finish but starts no new one
  assign conv_enable_o = active_q && fz_q == FZ_RUN;

  // ****************************************
  // checks
  // ****************************************
  AST_WR_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_acc && word == `IDX_SEQ_CTL |=> abort_o ##1 !active_q)
    else $error("control write did not abort the sequence");

  AST_LEN_DONE: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && pos_q + 4'h1 == seq_len_o && !clear_cnt |=> seq_done_o && pos_q == 4'h0)
    else $error("sequence did not end at its length");

  AST_RESET_LEN: assert property (@(posedge clk_i)
    rst_i |=> seq_len_o == 4'h4 && !fifo_mode_o)
    else $error("length after reset is not four");

  AST_SLOT_INDEX: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && !fifo_mode_o && !clear_cnt |-> cnt_q == pos_q[2:0])
    else $error("result slot differs from sequence position");

  AST_FIFO_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && fifo_mode_o && last && cnt_q != `CNT_LAST && !clear_cnt
    |=> cnt_q != 3'h0)
    else $error("fifo counter reset at sequence end");

  AST_FIFO_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && fifo_mode_o && cnt_q == `CNT_LAST && !clear_cnt |=> cnt_q == 3'h0)
    else $error("fifo counter did not wrap");

  AST_STATUS_CNT: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_ack_o && !wb_we_i && word == `IDX_STATUS0
    |=> wb_ack_o && wb_dat_o[2:0] == $past(cnt_q))
    else $error("status read lost the counter");

  AST_CLEAR_CNT: assert property (@(posedge clk_i) disable iff (rst_i)
    clear_cnt |=> cnt_q == 3'h0)
    else $error("counter not cleared by abort or start");

  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    accept && !clear_cnt |=> ccf[$past(cnt_q)])
    else $error("complete flag not set for written slot");

  AST_FRZ_NOW: assert property (@(posedge clk_i) disable iff (rst_i)
    fz_q != FZ_DRAIN && freeze_i && frz == `FRZ_NOW |=> halt_o)
    else $error("immediate freeze not entered");

  AST_FRZ_CONT: assert property (@(posedge clk_i) disable iff (rst_i)
    fz_q == FZ_RUN && frz == `FRZ_CONTINUE |=> !halt_o)
    else $error("continue mode froze");

  AST_FAST_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    acc && res_hit && fast_clr_q && !(accept && cnt_q == word[2:0])
    |=> !ccf[$past(word[2:0])])
    else $error("fast clear left the flag set");

  AST_FRZ_DRAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    fz_q == FZ_DRAIN && freeze_i && !conv_busy_i |=> halt_o)
    else $error("finish then freeze did not freeze after the conversion");

  AST_FRZ_RSVD: assert property (@(posedge clk_i) disable iff (rst_i)
    fz_q == FZ_RUN && frz == `FRZ_RESERVED |=> !halt_o)
    else $error("reserved freeze code froze");

  AST_THAW: assert property (@(posedge clk_i) disable iff (rst_i)
    !freeze_i |=> !halt_o)
    else $error("halt held after the breakpoint ended");

  AST_ABORT_END: assert property (@(posedge clk_i) disable iff (rst_i)
    abort_o || abort_i |=> !active_q && !seq_done_o)
    else $error("abort left the sequence running");
endmodule // adc_sequence_fifo_freeze_ctrl

// file: adc_sequence_fifo_freeze_ctrl_tb.sv
// self-checking bench of the sequence length, result placement and freeze controller
// assumes the package, constants header and result file are compiled before it
`timescale 1ns/1ps
`include "adc_seq_consts.svh"
module adc_sequence_fifo_freeze_ctrl_tb
  import adc_seq_pkg::*;
;
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]   wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o, rd;
  logic         abort_i, start_i, scan_i, freeze_i, conv_busy_i;
  conv_result_t conv_result_i;
  logic [3:0]   seq_len_o;
  logic         fifo_mode_o, abort_o, seq_done_o, conv_enable_o, halt_o;
  int           failures, n_checks, done_n;
  // write byte beside the length it should give
  logic [11:0]  rows [10] = '{12'h008, 12'h081, 12'h102, 12'h183, 12'h204,
                              12'h285, 12'h306, 12'h387, 12'h408, 12'hFE8};

  adc_sequence_fifo_freeze_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .abort_i(abort_i),
    .start_i(start_i), .scan_i(scan_i), .external_trigger_mode_i(1'b0),
    .freeze_i(freeze_i), .conv_busy_i(conv_busy_i), .conv_result_i(conv_result_i),
    .seq_len_o(seq_len_o), .fifo_mode_o(fifo_mode_o), .abort_o(abort_o),
    .seq_done_o(seq_done_o), .conv_enable_o(conv_enable_o), .halt_o(halt_o));

  // 40 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // count sequence completions, pulses are too short to poll
  always @(posedge clk_i)
  begin
    if (seq_done_o === 1'b1) done_n <= done_n + 1;
  end

  // ****************
  // tasks
  // ****************
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // classic cycle; slave latency never assumed, bounded wait instead
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
    begin
      @(posedge clk_i);
      n++;
      if (n > 8)
      begin
        failures++;
        results();
      end
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic res(input logic [9:0] d);
    conv_result_i <= '{valid: 1'b1, data: d};
    @(posedge clk_i);
    conv_result_i <= '{valid: 1'b0, data: 10'h000};
    @(posedge clk_i);
  endtask

  // one-cycle pulse on abort_i or start_i
  task automatic pulse(input logic ab);
    if (ab) abort_i <= 1'b1;
    else start_i <= 1'b1;
    @(posedge clk_i);
    abort_i <= 1'b0;
    start_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, abort_i, start_i, scan_i, freeze_i, conv_busy_i} = 8'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    conv_result_i = '0;
    {failures, n_checks, done_n} = 96'h0;
    rst_i = 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    chk(32'(seq_len_o), 32'h4);
    wb(1'b0, 8'h0C, 8'h00);
    chk(rd, 32'h20);
    wb(1'b0, 8'h7C, 8'h00);
    chk(rd, 32'h0);
    // length coding, fifo bit and bit seven
    foreach (rows[i])
    begin
      wb(1'b1, 8'h0C, rows[i][11:4]);
      chk(32'(seq_len_o), 32'(rows[i][3:0]));
      chk(32'(fifo_mode_o), 32'(rows[i][6]));
      wb(1'b0, 8'h0C, 8'h00);
      chk(rd, 32'(rows[i][11:4] & 8'h7F));
    end
    // fixed slots, flags, normal clear, write abort
    wb(1'b1, 8'h0C, 8'h10);
    pulse(1'b0);
    res(10'h111);
    res(10'h222);
    tick(1);
    chk(32'(done_n), 32'd1);
    wb(1'b0, 8'h2C, 8'h00);
    chk(rd, 32'h03);
    wb(1'b0, 8'h40, 8'h00);
    chk(rd, 32'h111);
    wb(1'b0, 8'h44, 8'h00);
    chk(rd, 32'h222);
    wb(1'b0, 8'h2C, 8'h00);
    chk(rd, 32'h00);
    pulse(1'b0);
    res(10'h333);
    wb(1'b0, 8'h2C, 8'h00);
    chk(rd, 32'h01);
    wb(1'b1, 8'h0C, 8'h10);
    chk(32'(abort_o), 32'h1);
    tick(1);
    chk(32'(conv_enable_o), 32'h0);
    res(10'h3AA);
    wb(1'b0, 8'h40, 8'h00);
    chk(rd, 32'h333);
    // fifo with scan: counter kept across sequences and wraps
    wb(1'b1, 8'h0C, 8'h1C);
    scan_i <= 1'b1;
    pulse(1'b0);
    for (int i = 1; i <= 10; i++) res(10'(i));
    chk(32'(done_n), 32'd4);
    wb(1'b0, 8'h18, 8'h00);
    chk(rd, 32'h0A);
    pulse(1'b0);
    wb(1'b0, 8'h18, 8'h00);
    chk(rd, 32'h08);
    pulse(1'b1);
    scan_i <= 1'b0;
    wb(1'b0, 8'h18, 8'h00);
    chk(rd, 32'h00);
    wb(1'b0, 8'h40, 8'h00);
    chk(rd, 32'h9);
    wb(1'b0, 8'h44, 8'h00);
    chk(rd, 32'hA);
    // fast clear: any access to a slot drops its flag
    wb(1'b1, 8'h08, 8'h40);
    wb(1'b0, 8'h48, 8'h00);
    chk(rd, 32'h3);
    wb(1'b1, 8'h4C, 8'h00);
    wb(1'b0, 8'h2C, 8'h00);
    chk(rd, 32'hF3);
    wb(1'b1, 8'h08, 8'h00);
    // every freeze code, converter busy then idle
    for (int c = 0; c < 4; c++)
    begin
      wb(1'b1, 8'h0C, 8'h08 | 8'(c));
      scan_i <= 1'b1;
      conv_busy_i <= 1'b1;
      pulse(1'b0);
      freeze_i <= 1'b1;
      tick(3);
      chk(32'(halt_o), 32'(c == 3));
      conv_busy_i <= 1'b0;
      tick(3);
      chk(32'(halt_o), 32'(c >= 2));
      chk(32'(conv_enable_o), 32'(c < 2));
      freeze_i <= 1'b0;
      tick(3);
      chk(32'(halt_o), 32'h0);
    end
    // reset in mid-run restores length four
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    chk(32'(seq_len_o), 32'h4);
    wb(1'b0, 8'h0C, 8'h00);
    chk(rd, 32'h20);
    results();
  end
endmodule // adc_sequence_fifo_freeze_ctrl_tb
